// ==== conv_ctrl.v ====
// Control, result and output code registers for the delta-sigma converter.
//
// Overview of operation
// - Low nibble write goes to shadow first.
// - Output enable bit 7 gates the DAC.
// - Reference select: regulator, supply, common mode.
// - Three read-only result bytes hold 24 bits.
// - Filter reset holds filter outside sleep and power-off, aborts conversion.
// - Sleep stops modulator, keeps amp and filter.
// - Power-off resets to 1 and overrides sleep and reset.
// - Oversampling field halves rate per step.
// - Reference pair: internal or external pins.
// - Filter mode sets factor_a and clock division.
// - Factor_a 2 doubles samples, factor_a 1 low-latency.
// - Reference buffer bits enable buffer outside sleep and power-off, drop bypass.
// - Latch freezes results and completion flag.
// - Done flag set by hardware, software clears.
// - Clock divider field: halve then divide, all ones passes through.
// - Power-down keeps only regulator-led circuits.
// - Normal or reset mode by filter reset.
// - Each unlatched conversion end sets done, pulses request.
// - Unlatched results update every conversion.
// - Results saturate to 24-bit two's complement.
//
// All logic runs on pclk; slower rates are one-cycle enables.
// Each register is one aligned APB word, data in the low byte.
// An unmapped address raises pslverr.
`timescale 1ns/10ps
`default_nettype none
`include "conv_ctrl_defs.vh"

module conv_ctrl (
    // Clock and reset.
    input  wire        pclk,             // System clock, 50 MHz.
    input  wire        presetn,          // Asynchronous reset, active low.

    // APB slave.
    input  wire        psel,             // APB select.
    input  wire        penable,          // APB access phase.
    input  wire        pwrite,           // APB direction, high for write.
    input  wire [11:0] paddr,            // APB byte address.
    input  wire [31:0] pwdata,           // APB write data.
    output wire [31:0] prdata,           // APB read data.
    output wire        pready,           // APB ready, always high.
    output wire        pslverr,          // APB error on unmapped address.

    // Filter output, taken at conversion end.
    input  wire [25:0] sample_in,        // Signed wide filter output.

    // Output converter.
    output reg  [11:0] out_code,         // Live DAC output code.
    output reg         out_conv_enable,  // DAC enabled.
    output reg  [1:0]  out_ref_select,   // DAC reference selector.
    output reg         use_regulator_ref,// DAC reference is regulator output.
    output reg         use_supply_ref,   // DAC reference is supply input.
    output reg         use_cm_ref,       // DAC reference is common mode.

    // Converter reference and power.
    output reg         ref_pair_external,// Converter uses external pins.
    output reg         neg_buf_on,       // Negative reference buffer on.
    output reg         pos_buf_on,       // Positive reference buffer on.
    output reg         bias_on,          // Bandgap, regulator, common mode.
    output reg         amp_on,           // Amplifier powered.
    output reg         modulator_on,     // Modulator running.
    output reg         filter_on,        // Decimation filter powered.
    output reg         filter_hold,      // Decimation filter held reset.

    // Clock enables and request pulse.
    output reg         mclk_tick,        // Modulator clock source enable.
    output reg         adck_tick,        // Converter clock enable.
    output reg         done_pulse        // Interrupt request pulse.
);

    // Register state.
    reg [7:0]  out_code_high_q;   // Output code bits 11..4.
    reg [3:0]  out_code_low_q;    // Live low nibble.
    reg [3:0]  low_shadow_q;      // Shadow of the low nibble.
    reg [7:0]  out_ctrl_q;        // Output converter control.

    // Converter control registers.
    reg [7:0]  ctrl_zero_q;       // Converter control zero.
    reg [7:0]  ctrl_one_q;        // Converter control one.
    reg [7:0]  clk_sel_q;         // Converter clock select.
    reg        regulator_enable_q;// Regulator enable.

    // Result and conversion timing.
    reg [23:0] result_q;          // Latest conversion result.
    reg [4:0]  mdiv_q;            // Modulator clock divider count.
    reg        mhalf_q;           // Divide-by-two phase.
    reg [4:0]  ndiv_q;            // Converter clock divider count.
    reg [14:0] osr_cnt_q;         // Oversampling counter.
    reg        factor_a_q;            // Second factor_a phase.

    // Read data flip-flop.
    reg [31:0] rdata_q;           // Registered read data.

    // Decoded fields.
    wire       wr_en   = psel & penable & pwrite;
    wire       rd_set  = psel & ~penable & ~pwrite;

    // Mode bits.
    wire       pwr_off = ctrl_zero_q[`BIT_POWER_OFF];
    wire       sleep   = ctrl_zero_q[`BIT_SLEEP];
    wire       frst    = ctrl_zero_q[`BIT_FILTER_RESET];
    wire [2:0] osr_sel = ctrl_zero_q[`BIT_OSR_HI:`BIT_OSR_LO];
    wire [2:0] fmode   = ctrl_one_q[`BIT_FMODE_HI:`BIT_FMODE_LO];
    wire       latch   = ctrl_one_q[`BIT_LATCH];
    wire [4:0] ckdiv   = clk_sel_q[4:0];

    // Mode bit 2 picks factor_a, bit 1 the divider.
    wire       factor_a_two = ~fmode[2];
    wire [4:0] ndiv    = fmode[1] ? `DIV_SHORT : `DIV_LONG;
    // Conversions run only in normal mode.
    wire       running = ~pwr_off & ~sleep & ~frst;
    // The rate halves at each step.
    wire [14:0] osr_len = `OSR_MAX >> osr_sel;

    // Driven further down.
    wire       conv_end;
    reg        mapped;
    reg [31:0] rmux;

    // Address decode and read mux; reserved bits read zero.
    always @* begin
        mapped = 1'b1;
        rmux   = 32'h0000_0000;
        // Unused upper bits read zero.
        case (paddr)
            `OFS_OUT_CODE_HIGH: rmux[7:0] = out_code_high_q;
            `OFS_OUT_CODE_LOW:  rmux[3:0] = out_code_low_q;
            `OFS_OUT_CTRL:      rmux[7:0] = out_ctrl_q;
            // Result bytes, low to high.
            `OFS_RESULT_LOW:    rmux[7:0] = result_q[7:0];
            `OFS_RESULT_MID:    rmux[7:0] = result_q[15:8];
            `OFS_RESULT_HIGH:   rmux[7:0] = result_q[23:16];
            `OFS_CTRL_ZERO:     rmux[7:0] = ctrl_zero_q;
            `OFS_CTRL_ONE:      rmux[7:0] = ctrl_one_q;
            `OFS_CLOCK_SELECT:  rmux[7:0] = clk_sel_q;
            `OFS_REG_ENABLE:    rmux[0]   = regulator_enable_q;
            default:            mapped    = 1'b0;
        endcase
    end

    // Every access takes one cycle.
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = rdata_q;

    // Read data is captured in the setup cycle for the access phase.
    // This keeps prdata a flip-flop output.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_set) begin
            // Capture the addressed register.
            rdata_q <= rmux;
        end
    end

    // Software writable registers and the output code shadow.
    // Writes to result bytes change nothing.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_code_high_q    <= 8'h00;
            out_code_low_q     <= 4'h0;
            low_shadow_q       <= 4'h0;
            out_ctrl_q         <= `RST_OUT_CTRL;
            // The converter starts powered off.
            ctrl_zero_q        <= `RST_CTRL_ZERO;
            clk_sel_q          <= `RST_CLOCK_SELECT;
            regulator_enable_q <= 1'b0;
        end else if (wr_en) begin
            // Writes land at the access edge.
            case (paddr)
                // The low nibble only reaches the shadow.
                `OFS_OUT_CODE_LOW: begin
                    low_shadow_q <= pwdata[3:0];
                end
                // The high byte also loads the live low nibble from the shadow.
                `OFS_OUT_CODE_HIGH: begin
                    out_code_high_q <= pwdata[7:0];
                    out_code_low_q  <= low_shadow_q;
                end
                `OFS_OUT_CTRL: begin
                    out_ctrl_q <= pwdata[7:0] & `MASK_OUT_CTRL;
                end
                `OFS_CTRL_ZERO: begin
                    ctrl_zero_q <= pwdata[7:0] & `MASK_CTRL_ZERO;
                end
                `OFS_CLOCK_SELECT: begin
                    clk_sel_q <= pwdata[7:0] & `MASK_CLOCK_SELECT;
                end
                `OFS_REG_ENABLE: begin
                    regulator_enable_q <= pwdata[0];
                end
                // Read-only, unmapped and control one addresses.
                default: begin
                    regulator_enable_q <= regulator_enable_q;
                end
            endcase
        end
    end

    // Control one; hardware set of the done flag wins over a clear.
    // A clear in the same cycle loses.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_one_q <= `RST_CTRL_ONE;
        end else begin
            if (wr_en && paddr == `OFS_CTRL_ONE) begin
                ctrl_one_q <= pwdata[7:0] & `MASK_CTRL_ONE;
            end

            // The set comes last.
            if (conv_end && !latch) begin
                ctrl_one_q[`BIT_DONE] <= 1'b1;
            end
        end
    end

    // Modulator clock source: halve then divide, or pass through.
    // A tick comes every 2*(field+1) cycles.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mdiv_q    <= 5'd0;
            mhalf_q   <= 1'b0;
            mclk_tick <= 1'b0;
        end else if (ckdiv == `CLKDIV_BYPASS) begin
            // Undivided: a tick every cycle.
            mdiv_q    <= 5'd0;
            mhalf_q   <= 1'b0;
            mclk_tick <= 1'b1;
        end else begin
            // Halve, then divide by field plus one.
            mhalf_q   <= ~mhalf_q;
            mclk_tick <= 1'b0;

            if (mhalf_q) begin
                if (mdiv_q >= ckdiv) begin
                    mdiv_q    <= 5'd0;
                    mclk_tick <= 1'b1;
                end else begin
                    mdiv_q <= mdiv_q + 5'd1;
                end
            end
        end
    end

    // Converter clock: modulator source divided by 30 or 12.
    // A count above a new limit wraps at once.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ndiv_q    <= 5'd0;
            adck_tick <= 1'b0;
        end else begin
            adck_tick <= 1'b0;

            // Advance only on modulator ticks.
            if (mclk_tick) begin
                if (ndiv_q >= ndiv - 5'd1) begin
                    ndiv_q    <= 5'd0;
                    adck_tick <= 1'b1;
                end else begin
                    ndiv_q <= ndiv_q + 5'd1;
                end
            end
        end
    end

    // Last tick of a run; with factor_a 2, of two.
    assign conv_end = running && adck_tick &&
                      (osr_cnt_q >= osr_len - 15'd1) &&
                      (factor_a_q || !factor_a_two);

    // Conversion sequencer; held and aborted while not running.
    // It restarts when normal mode returns.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osr_cnt_q  <= 15'd0;
            factor_a_q     <= 1'b0;
            done_pulse <= 1'b0;
        end else if (!running) begin
            // Reset, sleep or power-off aborts.
            osr_cnt_q  <= 15'd0;
            factor_a_q     <= 1'b0;
            done_pulse <= 1'b0;
        end else begin
            // The pulse rises with the flag, in the same cycle.
            done_pulse <= conv_end & ~latch;

            // Count ticks through one run.
            if (adck_tick) begin
                if (osr_cnt_q >= osr_len - 15'd1) begin
                    osr_cnt_q <= 15'd0;
                    factor_a_q    <= factor_a_two & ~factor_a_q;
                end else begin
                    osr_cnt_q <= osr_cnt_q + 15'd1;
                end
            end
        end
    end

    // Result register with saturation and latch freeze.
    // The filter output is two bits wider.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= 24'h000000;
        end else if (conv_end && !latch) begin
            // Clamp what does not fit in 24 bits.
            if (!sample_in[25] && |sample_in[24:23]) begin
                result_q <= 24'h7FFFFF;
            end else if (sample_in[25] && ~&sample_in[24:23]) begin
                result_q <= 24'h800000;
            end else begin
                // In range: take the low 24 bits.
                result_q <= sample_in[23:0];
            end
        end
    end

    // Analog control outputs from the mode decode.
    // Power-off wins over sleep and reset.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // All analog parts are off in reset.
            out_code          <= 12'h000;
            out_conv_enable   <= 1'b0;
            out_ref_select    <= 2'b00;
            use_regulator_ref <= 1'b0;
            use_supply_ref    <= 1'b0;
            use_cm_ref        <= 1'b0;

            ref_pair_external <= 1'b0;
            neg_buf_on        <= 1'b0;
            pos_buf_on        <= 1'b0;

            bias_on           <= 1'b0;
            amp_on            <= 1'b0;
            modulator_on      <= 1'b0;
            filter_on         <= 1'b0;
            filter_hold       <= 1'b0;
        end else begin
            // Live code, a cycle behind.
            out_code        <= {out_code_high_q, out_code_low_q};
            // Output enable and reference.
            out_conv_enable <= out_ctrl_q[`BIT_OUT_CONV_EN];
            out_ref_select  <= out_ctrl_q[`BIT_OUT_REF_HI:`BIT_OUT_REF_LO];
            use_regulator_ref <= out_ctrl_q[6:5] == 2'b00;
            use_supply_ref    <= out_ctrl_q[6:5] == 2'b01;
            use_cm_ref        <= out_ctrl_q[`BIT_OUT_REF_HI];

            // Reference pair and buffers.
            ref_pair_external <= ctrl_zero_q[`BIT_REF_PAIR];
            neg_buf_on   <= ~pwr_off & ~sleep &
                            ctrl_one_q[`BIT_NEG_BUF];
            pos_buf_on   <= ~pwr_off & ~sleep &
                            ctrl_one_q[`BIT_POS_BUF];

            // Power domains by mode.
            bias_on      <= ~pwr_off | regulator_enable_q;
            amp_on       <= ~pwr_off;
            modulator_on <= ~pwr_off & ~sleep;
            filter_on    <= ~pwr_off;
            filter_hold  <= ~pwr_off & ~sleep & frst;
        end
    end

endmodule // conv_ctrl
`default_nettype wire

// ==== conv_ctrl_defs.vh ====
// Register offsets, field positions, reset values and timing constants.
`ifndef CONV_CTRL_DEFS_VH
`define CONV_CTRL_DEFS_VH

// Byte addresses of the registers on the APB slave.
`define OFS_OUT_CODE_HIGH  12'h000
`define OFS_OUT_CODE_LOW   12'h004
`define OFS_OUT_CTRL       12'h008
`define OFS_RESULT_LOW     12'h00C
`define OFS_RESULT_MID     12'h010
`define OFS_RESULT_HIGH    12'h014
`define OFS_CTRL_ZERO      12'h018
`define OFS_CTRL_ONE       12'h01C
`define OFS_CLOCK_SELECT   12'h020
`define OFS_REG_ENABLE     12'h024

// Field positions in the output converter control register.
`define BIT_OUT_CONV_EN    7
`define BIT_OUT_REF_HI     6
`define BIT_OUT_REF_LO     5

// Field positions in converter control register zero.
`define BIT_FILTER_RESET   7
`define BIT_SLEEP          6
`define BIT_POWER_OFF      5
`define BIT_OSR_HI         4
`define BIT_OSR_LO         2
`define BIT_REF_PAIR       0

// Field positions in converter control register one.
`define BIT_FMODE_HI       7
`define BIT_FMODE_LO       5
`define BIT_NEG_BUF        4
`define BIT_POS_BUF        3
`define BIT_LATCH          2
`define BIT_DONE           1

// Reset values of the control registers.
`define RST_CTRL_ZERO      8'h20
`define RST_CTRL_ONE       8'h00
`define RST_OUT_CTRL       8'h00
`define RST_CLOCK_SELECT   8'h00

// Writable bit masks; other bits read as zero.
`define MASK_CTRL_ZERO     8'hFD
`define MASK_CTRL_ONE      8'hFE
`define MASK_OUT_CTRL      8'hE0
`define MASK_CLOCK_SELECT  8'h1F

// Timing: undivided clock divider code, division factors, largest rate.
`define CLKDIV_BYPASS      5'h1F
`define DIV_LONG           5'd30
`define DIV_SHORT          5'd12
`define OSR_MAX            15'h4000

`endif

// ==== conv_ctrl_assertions.sv ====
// Port-level checker for the converter control block.
`timescale 1ns/10ps
`default_nettype none
`include "conv_ctrl_defs.vh"
module conv_ctrl_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic [11:0] out_code,
    input wire logic        out_conv_enable,
    input wire logic [1:0]  out_ref_select,
    input wire logic        use_regulator_ref,
    input wire logic        use_supply_ref,
    input wire logic        use_cm_ref,
    input wire logic        amp_on,
    input wire logic        modulator_on,
    input wire logic        filter_on,
    input wire logic        filter_hold,
    input wire logic        done_pulse
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed write and read access phases.
    wire wr = psel && penable && pready && pwrite;
    wire rd = psel && penable && pready && !pwrite;
    AST_UNMAPPED_ERR: assert property (psel && penable &&
        paddr > `OFS_REG_ENABLE |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    AST_CTRL0_ZERO_BITS: assert property (rd &&
        paddr == `OFS_CTRL_ZERO |-> (prdata & ~32'h000000FD) == 32'h0)
        else $error("unimplemented bits read nonzero");
    AST_OUT_ENABLE: assert property (wr && paddr == `OFS_OUT_CTRL
        |-> ##2 out_conv_enable == $past(pwdata[7], 2))
        else $error("output enable does not follow write");
    AST_CODE_HIGH: assert property (wr && paddr == `OFS_OUT_CODE_HIGH
        |-> ##2 out_code[11:4] == $past(pwdata[7:0], 2))
        else $error("high byte of output code not loaded");
    AST_LOW_SHADOW: assert property (wr && paddr == `OFS_OUT_CODE_LOW
        |-> ##2 $stable(out_code))
        else $error("low nibble write reached live code");
    AST_REF_DECODE: assert property ($past(presetn) |->
        use_cm_ref == out_ref_select[1] &&
        use_supply_ref == (out_ref_select == 2'b01) &&
        use_regulator_ref == (out_ref_select == 2'b00))
        else $error("reference decode wrong");
    AST_MOD_POWER: assert property (modulator_on |->
        amp_on && filter_on)
        else $error("modulator runs without amplifier or filter");
    AST_HOLD_NO_DONE: assert property (filter_hold &&
        $past(filter_hold) |-> !done_pulse)
        else $error("conversion ended while filter held");
    AST_DONE_PULSE: assert property (done_pulse |=>
        !done_pulse [*8])
        else $error("completion pulse too long");
    // Main scenarios reached.
    COV_DONE: cover property (done_pulse);
    COV_HOLD: cover property (filter_hold);
    COV_ERR: cover property (pslverr);
    COV_CODE: cover property (wr && paddr == `OFS_OUT_CODE_HIGH);
endmodule // conv_ctrl_assertions
bind conv_ctrl conv_ctrl_assertions u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .out_code(out_code),
    .out_conv_enable(out_conv_enable), .out_ref_select(out_ref_select),
    .use_regulator_ref(use_regulator_ref), .use_supply_ref(use_supply_ref),
    .use_cm_ref(use_cm_ref), .amp_on(amp_on), .modulator_on(modulator_on),
    .filter_on(filter_on), .filter_hold(filter_hold),
    .done_pulse(done_pulse));
`default_nettype wire

// ==== tb_conv_ctrl.sv ====
// Self-checking APB testbench for the converter control block.
`timescale 1ns/10ps
`default_nettype none
`include "conv_ctrl_defs.vh"
module tb_conv_ctrl;
    logic        pclk, presetn, psel, penable, pwrite;  // Bench drives.
    logic [11:0] paddr;                  // Byte address.
    logic [31:0] pwdata, rdata;          // Write data and taken read data.
    logic [25:0] sample_in;              // Filter output seen by the block.
    logic        rerr;                   // Taken error response.
    wire  [31:0] prdata;                 // Read data.
    wire  [11:0] out_code;               // Live output code.
    wire  [1:0]  out_ref_select;         // Output reference select.
    wire         pready, pslverr, out_conv_enable, use_regulator_ref;
    wire         use_supply_ref, use_cm_ref, ref_pair_external, neg_buf_on;
    wire         pos_buf_on, bias_on, amp_on, modulator_on, filter_on;
    wire         filter_hold, mclk_tick, adck_tick, done_pulse;
    int          miscompares, num_checks, c, n;  // Counters.

    conv_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_in(sample_in), .out_code(out_code),
        .out_conv_enable(out_conv_enable), .out_ref_select(out_ref_select),
        .use_regulator_ref(use_regulator_ref), .use_supply_ref(use_supply_ref),
        .use_cm_ref(use_cm_ref), .ref_pair_external(ref_pair_external),
        .neg_buf_on(neg_buf_on), .pos_buf_on(pos_buf_on), .bias_on(bias_on),
        .amp_on(amp_on), .modulator_on(modulator_on), .filter_on(filter_on),
        .filter_hold(filter_hold), .mclk_tick(mclk_tick),
        .adck_tick(adck_tick), .done_pulse(done_pulse));

    // Clock of 50 MHz.
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Prints the counts and the verdict, then ends the run.
    task conclude;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Compares one value and counts the result.
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Counts an expired wait and stops.
    task expired;
        miscompares++;
        $display("MISMATCH %0t wait expired", $time);
        conclude();
    endtask

    // One APB transfer: setup, then access held until pready.
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) expired();
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rdata, e);
    endtask

    // Lets a written value reach the registered outputs.
    task settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask

    // Reset value, then the read-back of an all-ones write.
    task rw(input logic [11:0] a, input logic [7:0] r, input logic [7:0] m);
        rdchk(a, {24'h0, r});
        wr(a, 32'hFFFFFFFF);
        rdchk(a, {24'h0, m});
    endtask

    // Sets a mode and checks the power outputs.
    task mode(input logic [7:0] v, input logic [3:0] e);
        wr(`OFS_CTRL_ZERO, {24'h0, v});
        settle();
        chk({amp_on, modulator_on, filter_on, filter_hold}, e);
    endtask

    // Waits for the next completion pulse; c holds the cycles taken.
    task wait_done;
        c = 0;
        do begin
            @(posedge pclk);
            #1;
            c++;
        end while (done_pulse !== 1'b1 && c < 9000);
        if (c >= 9000) expired();
    endtask

    // Restarts conversions and measures one full result period.
    task period(input logic [7:0] ck, input logic [7:0] c1,
                input logic [7:0] c0, input int e);
        wr(`OFS_CLOCK_SELECT, {24'h0, ck});
        wr(`OFS_CTRL_ONE, {24'h0, c1});
        wr(`OFS_CTRL_ZERO, {24'h0, c0 | 8'h80});
        wr(`OFS_CTRL_ZERO, {24'h0, c0});
        wait_done();
        wait_done();
        chk(c, e);
    endtask

    // Counts clock enables over a whole number of their periods.
    task tick(input logic [7:0] ck, input logic [7:0] c1, input int em,
              input int ea);
        int nm, na;
        wr(`OFS_CLOCK_SELECT, {24'h0, ck});
        wr(`OFS_CTRL_ONE, {24'h0, c1});
        repeat (100) @(posedge pclk);
        nm = 0;
        na = 0;
        repeat (360) begin
            @(posedge pclk);
            #1;
            nm += mclk_tick;
            na += adck_tick;
        end
        chk(nm, em);
        chk(na, ea);
    endtask

    task res(input logic [23:0] e);
        rdchk(`OFS_RESULT_LOW, {24'h0, e[7:0]});
        rdchk(`OFS_RESULT_MID, {24'h0, e[15:8]});
        rdchk(`OFS_RESULT_HIGH, {24'h0, e[23:16]});
    endtask

    // Main sequence.
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        sample_in = 26'h0123456;
        miscompares = 0;
        num_checks = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rw(`OFS_OUT_CTRL, `RST_OUT_CTRL, `MASK_OUT_CTRL);
        rw(`OFS_CTRL_ZERO, `RST_CTRL_ZERO, `MASK_CTRL_ZERO);
        rw(`OFS_CTRL_ONE, `RST_CTRL_ONE, `MASK_CTRL_ONE);
        rw(`OFS_CLOCK_SELECT, `RST_CLOCK_SELECT, `MASK_CLOCK_SELECT);
        rw(`OFS_OUT_CODE_LOW, 8'h00, 8'h00);
        rw(`OFS_OUT_CODE_HIGH, 8'h00, 8'hFF);
        rdchk(`OFS_OUT_CODE_LOW, 32'hF);
        wr(`OFS_OUT_CODE_LOW, 32'hA);
        settle();
        chk(out_code, 12'hFFF);
        wr(`OFS_OUT_CODE_HIGH, 32'h5C);
        settle();
        chk(out_code, 12'h5CA);
        for (int i = 0; i < 8; i++) begin
            wr(`OFS_OUT_CTRL, {24'h0, i[2:0], 5'h0});
            settle();
            chk({out_conv_enable, out_ref_select, use_regulator_ref,
                use_supply_ref, use_cm_ref}, {i[2:0], i[1:0] == 2'b00,
                i[1:0] == 2'b01, i[1]});
        end
        wr(`OFS_CTRL_ZERO, 32'h20);
        wr(`OFS_REG_ENABLE, 32'h1);
        settle();
        chk(bias_on, 1'b1);
        wr(`OFS_REG_ENABLE, 32'h0);
        settle();
        chk(bias_on, 1'b0);
        mode(8'h20, 4'b0000);
        mode(8'hE0, 4'b0000);
        mode(8'h40, 4'b1010);
        mode(8'h80, 4'b1111);
        mode(8'h01, 4'b1110);
        wr(`OFS_CTRL_ONE, 32'h18);
        settle();
        chk({ref_pair_external, neg_buf_on, pos_buf_on}, 3'b111);
        wr(`OFS_CTRL_ONE, 32'h10);
        mode(8'h00, 4'b1110);
        chk({ref_pair_external, neg_buf_on, pos_buf_on}, 3'b010);
        xfer(1'b1, 12'h040, 32'hFF);
        chk(rerr, 1'b1);
        rdchk(12'h040, 32'h0);
        tick(8'h1F, 8'hC0, 360, 30);
        tick(8'h1F, 8'h00, 360, 12);
        tick(8'h00, 8'h00, 180, 6);
        tick(8'h02, 8'hC0, 60, 5);
        period(8'h1F, 8'h40, 8'h1C, 3072);
        period(8'h1F, 8'h80, 8'h18, 7680);
        period(8'h00, 8'hC0, 8'h1C, 3072);
        period(8'h1F, 8'hC0, 8'h1C, 1536);
        rdchk(`OFS_CTRL_ONE, 32'hC2);
        wait_done();
        rdchk(`OFS_CTRL_ONE, 32'hC2);
        wr(`OFS_CTRL_ONE, 32'hC0);
        rdchk(`OFS_CTRL_ONE, 32'hC0);
        wr(`OFS_CTRL_ONE, 32'hC4);
        sample_in <= 26'h1000000;
        n = 0;
        repeat (2000) begin
            @(posedge pclk);
            #1;
            n += done_pulse;
        end
        chk(n, 0);
        res(24'h123456);
        wr(`OFS_RESULT_LOW, 32'hAA);
        rdchk(`OFS_RESULT_LOW, 32'h56);
        rdchk(`OFS_CTRL_ONE, 32'hC4);
        wr(`OFS_CTRL_ONE, 32'hC0);
        wait_done();
        res(24'h7FFFFF);
        sample_in <= 26'h3000000;
        wait_done();
        res(24'h800000);
        conclude();
    end
endmodule // tb_conv_ctrl
`default_nettype wire
